// *** design/pmu_pkg.sv ***
package pmu_pkg;

  typedef logic [7:0] pmu_byte_t;

  // bus address of this device, write direction in bit 0 of the first byte
  localparam logic [6:0] DEV_ADDR = 7'h60;

  // register addresses
  localparam pmu_byte_t ADDR_THERMAL = 8'h02;
  localparam pmu_byte_t ADDR_SYSCTL = 8'h07;
  localparam pmu_byte_t ADDR_ENABLE = 8'h10;
  localparam pmu_byte_t ADDR_VALID = 8'h11;
  localparam pmu_byte_t ADDR_VCHANGE = 8'h20;
  localparam pmu_byte_t ADDR_B1_TGT_A = 8'h23;
  localparam pmu_byte_t ADDR_B1_TGT_B = 8'h24;
  localparam pmu_byte_t ADDR_B1_RAMP = 8'h25;
  localparam pmu_byte_t ADDR_B2_TGT_A = 8'h29;
  localparam pmu_byte_t ADDR_B2_TGT_B = 8'h2A;
  localparam pmu_byte_t ADDR_B2_RAMP = 8'h2B;
  localparam pmu_byte_t ADDR_BUCK_FUNC = 8'h38;
  localparam pmu_byte_t ADDR_LIN1_VOLT = 8'h39;
  localparam pmu_byte_t ADDR_LIN2_VOLT = 8'h3A;

  // number of writable registers, and storage index of the system, enable and voltage change registers
  localparam int NUM_RW = 12;
  localparam logic [3:0] IDX_SYSCTL = 4'h0;
  localparam logic [3:0] IDX_ENABLE = 4'h1;
  localparam logic [3:0] IDX_VCHANGE = 4'h2;
  localparam logic [3:0] IDX_NONE = 4'hF;

  // field positions
  localparam int SYS_CLKSRC_BIT = 0;
  localparam int SYS_BUCK_ONE_FORCED_PWM_BIT = 1;
  localparam int SYS_BUCK_TWO_FORCED_PWM_BIT = 2;
  localparam int SYS_PRESET_LSB = 4;
  localparam int VC_B1_GO_BIT = 0;
  localparam int VC_B1_SEL_BIT = 1;
  localparam int VC_B2_GO_BIT = 4;
  localparam int VC_B2_SEL_BIT = 5;
  localparam int THERM_HOT_BIT = 1;

  // target voltage defaults, plain values
  localparam logic [4:0] B1_TGT_DEFAULT = 5'h09;
  localparam logic [4:0] B2_TGT_DEFAULT = 5'h17;

  localparam pmu_byte_t REG_RST [NUM_RW] = '{
    8'h28, 8'h75, 8'h00, {3'h0, B1_TGT_DEFAULT}, {3'h0, B1_TGT_DEFAULT}, 8'h28,
    {3'h0, B2_TGT_DEFAULT}, {3'h0, B2_TGT_DEFAULT}, 8'h28, 8'h00, 8'h00, 8'h00};
  localparam pmu_byte_t REG_MASK [NUM_RW] = '{
    8'h77, 8'h55, 8'h33, 8'h1F, 8'h1F, 8'h0F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'hFF, 8'hFF};

  // timing: sequence delays are whole multiples of half a millisecond
  localparam int CLK_FREQ_MHZ = 20;
  localparam int DLY_STEP_US = 500;
  localparam int DLY_STEP_CYC = DLY_STEP_US * CLK_FREQ_MHZ;
  localparam int DEGLITCH_US = 1000;
  localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_FREQ_MHZ;

  // delay in half-ms steps for regulator ch (0 buck1, 1 buck2, 2 linreg1, 3 linreg2)
  function automatic logic [4:0] pmuDelaySteps(input logic [2:0] preset,
                                               input logic [1:0] ch);
    logic [19:0] row;
    row = 20'h0;
    case (preset)
      3'h0: row = {5'd2, 5'd2, 5'd2, 5'd2};
      3'h1: row = {5'd4, 5'd4, 5'd3, 5'd2};
      3'h3: row = {5'd2, 5'd2, 5'd4, 5'd3};
      3'h5: row = {5'd4, 5'd4, 5'd3, 5'd3};
      3'h6: row = {5'd3, 5'd2, 5'd4, 5'd6};
      3'h7: row = {5'd22, 5'd12, 5'd6, 5'd4};
      default: row = {5'd12, 5'd6, 5'd4, 5'd3};
    endcase
    return row[5 * ch +: 5];
  endfunction

endpackage

// *** design/pmu_regbank.sv ***
`timescale 1ns/100ps
module pmu_regbank #(
  parameter int unsigned STEP_CYCLES = pmu_pkg::DLY_STEP_CYC,
  parameter int unsigned DEGLITCH_CYCLES = pmu_pkg::DEGLITCH_CYC
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // serial bus, data is open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // power pins and analog status
  input wire logic seqTrigger,
  input wire logic [3:0] extEnable,
  input wire logic [3:0] outputValid,
  input wire logic overTemp,
  // regulator control
  output logic [3:0] regulatorOn,
  output logic buckOneForcedPwm,
  output logic buckTwoForcedPwm,
  output logic buckClockSource,
  output logic buckOneTargetSelect,
  output logic buckTwoTargetSelect,
  output logic buckOneRampGo,
  output logic buckTwoRampGo,
  // raw register contents for the analog side
  output pmu_pkg::pmu_byte_t buckOneTargetA,
  output pmu_pkg::pmu_byte_t buckOneTargetB,
  output pmu_pkg::pmu_byte_t buckOneRamp,
  output pmu_pkg::pmu_byte_t buckTwoTargetA,
  output pmu_pkg::pmu_byte_t buckTwoTargetB,
  output pmu_pkg::pmu_byte_t buckTwoRamp,
  output pmu_pkg::pmu_byte_t buckFunction,
  output pmu_pkg::pmu_byte_t linregOneVoltage,
  output pmu_pkg::pmu_byte_t linregTwoVoltage
);
  import pmu_pkg::*;

  typedef enum logic [3:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_REG,
    BUS_REG_ACK,
    BUS_WDATA,
    BUS_WDATA_ACK,
    BUS_RDATA,
    BUS_RDATA_ACK
  } pmu_bus_state_t;

  function automatic logic [3:0] regIndex(input pmu_byte_t addr);
    logic [3:0] idx;
    idx = IDX_NONE;
    if (addr == ADDR_SYSCTL) begin
      idx = 4'h0;
    end else if (addr == ADDR_ENABLE) begin
      idx = 4'h1;
    end else if (addr == ADDR_VCHANGE) begin
      idx = 4'h2;
    end else if (addr == ADDR_B1_TGT_A) begin
      idx = 4'h3;
    end else if (addr == ADDR_B1_TGT_B) begin
      idx = 4'h4;
    end else if (addr == ADDR_B1_RAMP) begin
      idx = 4'h5;
    end else if (addr == ADDR_B2_TGT_A) begin
      idx = 4'h6;
    end else if (addr == ADDR_B2_TGT_B) begin
      idx = 4'h7;
    end else if (addr == ADDR_B2_RAMP) begin
      idx = 4'h8;
    end else if (addr == ADDR_BUCK_FUNC) begin
      idx = 4'h9;
    end else if (addr == ADDR_LIN1_VOLT) begin
      idx = 4'hA;
    end else if (addr == ADDR_LIN2_VOLT) begin
      idx = 4'hB;
    end
    return idx;
  endfunction

  // pin synchronisers
  logic sclS;
  logic sdaS;
  logic trigS;
  logic [3:0] extS;
  logic [3:0] validS;
  logic hotS;

  pmu_sync2 #(.W(12)) pinSync (
    .clk(clk),
    .rstn(rstn),
    .d({sclIn, sdaIn, seqTrigger, extEnable, outputValid, overTemp}),
    .q({sclS, sdaS, trigS, extS, validS, hotS})
  );

  // bus line edges and framing
  logic sclPrev_q;
  logic sdaPrev_q;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclRise = sclS & ~sclPrev_q;
  assign sclFall = ~sclS & sclPrev_q;
  assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // serial slave state
  pmu_bus_state_t state_q;
  pmu_bus_state_t state_d;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  pmu_byte_t shift_q;
  pmu_byte_t shift_d;
  pmu_byte_t ptr_q;
  pmu_byte_t ptr_d;
  logic readDir_q;
  logic readDir_d;
  logic sdaOe_q;
  logic sdaOe_d;
  logic wrStb;
  pmu_byte_t rdData;

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    readDir_d = readDir_q;
    sdaOe_d = sdaOe_q;
    wrStb = 1'b0;
    if (startCond) begin
      state_d = BUS_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d = 1'b0;
    end else if (stopCond) begin
      state_d = BUS_IDLE;
      sdaOe_d = 1'b0;
    end else begin
      case (state_q)
        BUS_ADDR, BUS_REG, BUS_WDATA: begin
          if (sclRise && bitCnt_q != 4'h8) begin
            shift_d = {shift_q[6:0], sdaS};
            bitCnt_d = 4'(bitCnt_q + 4'h1);
          end else if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_d = 4'h0;
            if (state_q == BUS_ADDR) begin
              // foreign addresses are left alone until the next start
              if (shift_q[7:1] == DEV_ADDR) begin
                state_d = BUS_ADDR_ACK;
                sdaOe_d = 1'b1;
                readDir_d = shift_q[0];
              end else begin
                state_d = BUS_IDLE;
              end
            end else if (state_q == BUS_REG) begin
              state_d = BUS_REG_ACK;
              sdaOe_d = 1'b1;
              ptr_d = shift_q;
            end else begin
              state_d = BUS_WDATA_ACK;
              sdaOe_d = 1'b1;
              wrStb = 1'b1;
            end
          end
        end
        BUS_ADDR_ACK, BUS_REG_ACK, BUS_WDATA_ACK: begin
          if (sclFall) begin
            if (state_q == BUS_ADDR_ACK && readDir_q) begin
              // read uses the pointer left by the preceding write phase
              state_d = BUS_RDATA;
              shift_d = rdData;
              sdaOe_d = ~rdData[7];
              bitCnt_d = 4'h1;
            end else begin
              state_d = (state_q == BUS_ADDR_ACK) ? BUS_REG : BUS_WDATA;
              sdaOe_d = 1'b0;
            end
          end
        end
        BUS_RDATA: begin
          if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              state_d = BUS_RDATA_ACK;
              sdaOe_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sdaOe_d = ~shift_q[6];
              bitCnt_d = 4'(bitCnt_q + 4'h1);
            end
          end
        end
        BUS_RDATA_ACK: begin
          if (sclRise) begin
            if (sdaS) begin
              state_d = BUS_IDLE;
            end else begin
              bitCnt_d = 4'h0;
            end
          end else if (sclFall && bitCnt_q == 4'h0) begin
            state_d = BUS_RDATA;
            shift_d = rdData;
            sdaOe_d = ~rdData[7];
            bitCnt_d = 4'h1;
          end
        end
        default: begin
          state_d = BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= BUS_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      readDir_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      readDir_q <= readDir_d;
      sdaOe_q <= sdaOe_d;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;

  // register storage
  pmu_byte_t regs_q [NUM_RW];
  logic [3:0] wrIdx;
  logic [3:0] rdIdx;

  // read-only and unmapped addresses never match, so their writes drop out
  assign wrIdx = regIndex(ptr_q);
  assign rdIdx = regIndex(ptr_q);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++) begin : gReg
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          regs_q[gi] <= REG_RST[gi];
        end else if (wrStb && wrIdx == 4'(gi)) begin
          regs_q[gi] <= (regs_q[gi] & ~REG_MASK[gi]) | (shift_q & REG_MASK[gi]);
        end
      end
    end
  endgenerate

  // read mux
  pmu_byte_t thermalByte;
  pmu_byte_t validByte;
  logic bucksValid;
  logic linregsValid;

  assign thermalByte = {6'h00, hotS, 1'b0};
  assign bucksValid = validS[0] & validS[1];
  assign linregsValid = validS[2] & validS[3];
  assign validByte = {bucksValid, linregsValid, validS[3], validS[2], 1'b0,
                      validS[1], 1'b0, validS[0]};

  always_comb begin
    rdData = 8'h00;
    if (ptr_q == ADDR_THERMAL) begin
      rdData = thermalByte;
    end else if (ptr_q == ADDR_VALID) begin
      rdData = validByte;
    end else if (rdIdx != IDX_NONE) begin
      rdData = regs_q[rdIdx];
    end
  end

  // field decode
  pmu_byte_t sysCtl;
  pmu_byte_t enables;
  pmu_byte_t vChange;
  logic [2:0] delayPreset;

  assign sysCtl = regs_q[IDX_SYSCTL];
  assign enables = regs_q[IDX_ENABLE];
  assign vChange = regs_q[IDX_VCHANGE];
  assign delayPreset = sysCtl[SYS_PRESET_LSB +: 3];

  // trigger deglitch: a level must hold for the whole window before it counts
  logic [23:0] glitchCnt_q;
  logic trigStable_q;
  logic trigEdge_q;
  logic glitchDone;

  assign glitchDone = (glitchCnt_q == 24'(DEGLITCH_CYCLES - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      glitchCnt_q <= 24'h0;
      trigStable_q <= 1'b0;
      trigEdge_q <= 1'b0;
    end else begin
      trigEdge_q <= 1'b0;
      if (trigS == trigStable_q) begin
        glitchCnt_q <= 24'h0;
      end else if (glitchDone) begin
        glitchCnt_q <= 24'h0;
        trigStable_q <= trigS;
        trigEdge_q <= 1'b1;
      end else begin
        glitchCnt_q <= 24'(glitchCnt_q + 24'h1);
      end
    end
  end

  // per-regulator sequencing and gating
  logic [3:0] seqOn;
  logic [3:0] regOn_q;

  generate
    for (gi = 0; gi < 4; gi++) begin : gSeq
      pmu_seq_if seqLink ();
      assign seqLink.start = trigEdge_q;
      assign seqLink.target = trigStable_q;
      assign seqLink.steps = pmuDelaySteps(delayPreset, 2'(gi));
      assign seqOn[gi] = seqLink.on;

      pmu_seq_channel #(.STEP_CYCLES(STEP_CYCLES)) chan (
        .clk(clk),
        .rstn(rstn),
        .link(seqLink)
      );

      // external pins tied low leave the timed sequence in charge
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          regOn_q[gi] <= 1'b0;
        end else begin
          regOn_q[gi] <= enables[2 * gi] & (extS[gi] | seqOn[gi]);
        end
      end
    end
  endgenerate

  assign regulatorOn = regOn_q;
  assign buckClockSource = sysCtl[SYS_CLKSRC_BIT];
  assign buckOneForcedPwm = sysCtl[SYS_BUCK_ONE_FORCED_PWM_BIT];
  assign buckTwoForcedPwm = sysCtl[SYS_BUCK_TWO_FORCED_PWM_BIT];
  assign buckOneTargetSelect = vChange[VC_B1_SEL_BIT];
  assign buckTwoTargetSelect = vChange[VC_B2_SEL_BIT];
  assign buckOneRampGo = vChange[VC_B1_GO_BIT];
  assign buckTwoRampGo = vChange[VC_B2_GO_BIT];
  assign buckOneTargetA = regs_q[3];
  assign buckOneTargetB = regs_q[4];
  assign buckOneRamp = regs_q[5];
  assign buckTwoTargetA = regs_q[6];
  assign buckTwoTargetB = regs_q[7];
  assign buckTwoRamp = regs_q[8];
  assign buckFunction = regs_q[9];
  assign linregOneVoltage = regs_q[10];
  assign linregTwoVoltage = regs_q[11];

endmodule

// *** design/pmu_seq_channel.sv ***
`timescale 1ns/100ps
module pmu_seq_channel #(
  parameter int unsigned STEP_CYCLES = pmu_pkg::DLY_STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sequencer link
  pmu_seq_if.chan link
);
  import pmu_pkg::*;

  logic [23:0] pre_q;
  logic [4:0] step_q;
  logic [4:0] steps_q;
  logic target_q;
  logic busy_q;
  logic on_q;
  logic stepDone;
  logic lastStep;

  assign stepDone = (pre_q == 24'(STEP_CYCLES - 1));
  assign lastStep = (5'(step_q + 5'd1) == steps_q);
  assign link.on = on_q;

  // the delay is latched at the start, so later preset writes cannot disturb it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
      step_q <= '0;
      steps_q <= '0;
      target_q <= 1'b0;
      busy_q <= 1'b0;
      on_q <= 1'b0;
    end else if (link.start) begin
      pre_q <= '0;
      step_q <= '0;
      steps_q <= link.steps;
      target_q <= link.target;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      pre_q <= stepDone ? 24'h0 : 24'(pre_q + 24'h1);
      if (stepDone) begin
        step_q <= 5'(step_q + 5'd1);
        if (lastStep) begin
          on_q <= target_q;
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule

// *** design/pmu_seq_if.sv ***
`timescale 1ns/100ps
interface pmu_seq_if;
  logic start;
  logic target;
  logic [4:0] steps;
  logic on;
  modport ctrl (output start, output target, output steps, input on);
  modport chan (input start, input target, input steps, output on);
endinterface

// *** design/pmu_sync2.sv ***
`timescale 1ns/100ps
module pmu_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// *** tb/pmu_i2c_host.sv ***
`timescale 1ns/100ps
module pmu_i2c_host (
  // bus pins, data only ever pulled low
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  import pmu_pkg::*;
  // quarter of the 400 ns bus clock period
  localparam int Q = 100;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // data moves mid-low, sampled mid-high
  task automatic bitIo(input logic b, output logic r);
    #Q sdaLow = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  // odd extra delay keeps bus edges drifting against the system clock
  task automatic cond(input logic stopNotStart);
    #(Q + 7) sdaLow = stopNotStart;
    #Q scl = 1'b1;
    #Q sdaLow = ~stopNotStart;
    #Q scl = stopNotStart;
  endtask
  task automatic byteIo(input pmu_byte_t tx, output pmu_byte_t rx, output logic nak);
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(1'b1, nak);
  endtask
  task automatic writeReg(input logic [7:0] dev, input pmu_byte_t a, input pmu_byte_t d,
                          output logic nak);
    pmu_byte_t rx;
    logic n0, n1, n2;
    cond(1'b0);
    byteIo(dev, rx, n0);
    byteIo(a, rx, n1);
    byteIo(d, rx, n2);
    cond(1'b1);
    nak = n0 | n1 | n2;
  endtask
  task automatic readReg(input pmu_byte_t a, output pmu_byte_t d);
    pmu_byte_t rx;
    logic n;
    cond(1'b0);
    byteIo({DEV_ADDR, 1'b0}, rx, n);
    byteIo(a, rx, n);
    cond(1'b0);
    byteIo({DEV_ADDR, 1'b1}, rx, n);
    byteIo(8'hFF, d, n);
    cond(1'b1);
  endtask
endmodule

// *** tb/pmu_regbank_properties.sv ***
`timescale 1ns/100ps
module pmu_regbank_properties #(
  parameter int unsigned STEP_CYCLES = 4,
  parameter int unsigned DEGLITCH_CYCLES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus and pins
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic seqTrigger,
  input wire logic [3:0] extEnable,
  // controls
  input wire logic [3:0] regulatorOn,
  input wire logic buckClockSource,
  input wire logic buckOneForcedPwm,
  input wire logic buckTwoForcedPwm,
  input wire logic buckOneTargetSelect,
  input wire logic buckTwoTargetSelect,
  input wire logic buckOneRampGo,
  input wire logic buckTwoRampGo,
  input wire pmu_pkg::pmu_byte_t buckOneRamp
);
  import pmu_pkg::*;
  localparam int MIN_ON = DEGLITCH_CYCLES + 2 * STEP_CYCLES;
  localparam int OFF_LIM = 22 * STEP_CYCLES + DEGLITCH_CYCLES + 16;
  int hiCnt;
  int loCnt;
  int offCnt;
  // counters saturate so a long idle stretch never wraps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hiCnt <= 0;
      loCnt <= 0;
      offCnt <= 0;
    end else begin
      hiCnt <= seqTrigger ? hiCnt + int'(hiCnt < 99999) : 0;
      loCnt <= !seqTrigger ? loCnt + int'(loCnt < 99999) : 0;
      offCnt <= (!seqTrigger && extEnable == 4'h0) ? offCnt + int'(offCnt < 99999) : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ack_low_scl;
    $rose(sdaOe) |-> !sclIn;
  endproperty
  a_ack_low_scl: assert property (p_ack_low_scl) else $error("data pulled with clock high");
  property p_ack_hold;
    // a driven bit spans one bus clock period, eight system clocks in all
    $rose(sdaOe) |=> sdaOe [*7];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("driven bit too short");
  property p_open_drain;
    sdaOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_sys_quiet;
    $changed({buckClockSource, buckOneForcedPwm, buckTwoForcedPwm}) |-> !sclIn;
  endproperty
  a_sys_quiet: assert property (p_sys_quiet) else $error("system control moved off a write");
  property p_vc_quiet;
    $changed({buckOneTargetSelect, buckTwoTargetSelect, buckOneRampGo, buckTwoRampGo}) |-> !sclIn;
  endproperty
  a_vc_quiet: assert property (p_vc_quiet) else $error("voltage change moved off a write");
  property p_ramp_rsvd;
    buckOneRamp[7:4] == 4'h2;
  endproperty
  a_ramp_rsvd: assert property (p_ramp_rsvd) else $error("reserved ramp bits changed");
  property p_on_late;
    (regulatorOn & ~$past(regulatorOn)) != 4'h0 && extEnable == 4'h0 |-> hiCnt >= MIN_ON;
  endproperty
  a_on_late: assert property (p_on_late) else $error("regulator on too early");
  property p_off_late;
    ($past(regulatorOn) & ~regulatorOn) != 4'h0 && extEnable == 4'h0 |-> loCnt >= MIN_ON;
  endproperty
  a_off_late: assert property (p_off_late) else $error("regulator off too early");
  property p_all_off;
    offCnt > OFF_LIM |-> regulatorOn == 4'h0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("regulator on without a source");
  c_ack: cover property ($rose(sdaOe));
  c_all_on: cover property (regulatorOn == 4'hF);
  c_ext_clk: cover property ($rose(buckClockSource));
endmodule
bind pmu_regbank pmu_regbank_properties #(
  .STEP_CYCLES(STEP_CYCLES), .DEGLITCH_CYCLES(DEGLITCH_CYCLES)
) u_props (
  .clk(clk), .rstn(rstn), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .seqTrigger(seqTrigger), .extEnable(extEnable), .regulatorOn(regulatorOn),
  .buckClockSource(buckClockSource), .buckOneForcedPwm(buckOneForcedPwm),
  .buckTwoForcedPwm(buckTwoForcedPwm), .buckOneTargetSelect(buckOneTargetSelect),
  .buckTwoTargetSelect(buckTwoTargetSelect), .buckOneRampGo(buckOneRampGo),
  .buckTwoRampGo(buckTwoRampGo), .buckOneRamp(buckOneRamp)
);

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import pmu_pkg::*;
  localparam int STEP = 40;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic seqTrigger = 1'b0;
  logic [3:0] extEnable = 4'h0;
  logic [3:0] outputValid = 4'h0;
  logic overTemp = 1'b0;
  logic scl, sdaLow, sdaOut, sdaOe;
  logic [3:0] regulatorOn;
  logic [6:0] ctl;
  pmu_byte_t raw [9];
  wire logic sda = ~sdaLow & ~sdaOe;
  pmu_byte_t rwAddr [12] = '{8'h07, 8'h10, 8'h20, 8'h23, 8'h24, 8'h25, 8'h29, 8'h2A,
                             8'h2B, 8'h38, 8'h39, 8'h3A};
  pmu_byte_t rwMask [12] = '{8'h77, 8'h55, 8'h33, 8'h1F, 8'h1F, 8'h0F, 8'h1F, 8'h1F,
                             8'h0F, 8'hFF, 8'hFF, 8'hFF};
  pmu_byte_t rwRst [12] = '{8'h28, 8'h75, 8'h00, 8'h09, 8'h09, 8'h28, 8'h17, 8'h17,
                            8'h28, 8'h00, 8'h00, 8'h00};
  // half-ms steps per preset: buck1, buck2, linreg1, linreg2
  int dly [32] = '{2, 2, 2, 2, 2, 3, 4, 4, 3, 4, 6, 12, 3, 4, 2, 2,
                   3, 4, 6, 12, 3, 3, 4, 4, 6, 4, 2, 3, 4, 6, 12, 22};
  pmu_byte_t expQ [$];
  pmu_byte_t gotVal;
  event gotEv;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'h2107;

  pmu_regbank #(.STEP_CYCLES(STEP), .DEGLITCH_CYCLES(4)) dut (
    .clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .seqTrigger(seqTrigger), .extEnable(extEnable), .outputValid(outputValid),
    .overTemp(overTemp), .regulatorOn(regulatorOn), .buckClockSource(ctl[0]),
    .buckOneForcedPwm(ctl[1]), .buckTwoForcedPwm(ctl[2]), .buckOneTargetSelect(ctl[3]),
    .buckTwoTargetSelect(ctl[4]), .buckOneRampGo(ctl[5]), .buckTwoRampGo(ctl[6]),
    .buckOneTargetA(raw[0]), .buckOneTargetB(raw[1]), .buckOneRamp(raw[2]),
    .buckTwoTargetA(raw[3]), .buckTwoTargetB(raw[4]), .buckTwoRamp(raw[5]),
    .buckFunction(raw[6]), .linregOneVoltage(raw[7]), .linregTwoVoltage(raw[8]));
  pmu_i2c_host host (.scl(scl), .sdaLow(sdaLow), .sda(sda));

  always #25 clk = ~clk;

  task automatic wrap_up();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic cmp(input pmu_byte_t got, input pmu_byte_t exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(gotEv) cmp(gotVal, expQ.pop_front());
  // expectation queued first; the pause lets the monitor take it
  task automatic note(input pmu_byte_t got, input pmu_byte_t exp);
    expQ.push_back(exp);
    gotVal = got;
    ->gotEv;
    #1;
  endtask
  task automatic rd(input pmu_byte_t a, input pmu_byte_t exp);
    pmu_byte_t d;
    host.readReg(a, d);
    note(d, exp);
  endtask
  task automatic wr(input pmu_byte_t a, input pmu_byte_t d);
    logic nak;
    host.writeReg({DEV_ADDR, 1'b0}, a, d, nak);
    note({7'h0, nak}, 8'h00);
  endtask
  // only spacing between regulators is exact; the deglitch offset is shared
  task automatic seqRun(input logic lvl, input int p);
    int t [4] = '{0, 0, 0, 0};
    int c = 0;
    @(negedge clk) seqTrigger = lvl;
    while (regulatorOn !== {4{lvl}} && c < 2000) begin
      @(negedge clk);
      c++;
      foreach (t[i]) if (regulatorOn[i] === lvl && t[i] == 0) t[i] = c;
    end
    note(8'(t[0] > dly[4 * p] * STEP), 8'h01);
    for (int i = 1; i < 4; i++) note(8'(t[i] - t[0]), 8'((dly[4 * p + i] - dly[4 * p]) * STEP));
  endtask

  initial begin
    pmu_byte_t d;
    pmu_byte_t e;
    logic nak;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h07, 8'h28);
    rd(8'h10, 8'h75);
    rd(8'h20, 8'h00);
    rd(8'h11, 8'h00);
    note({1'b0, ctl}, 8'h00);
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      wr(rwAddr[i], d);
      e = (d & rwMask[i]) | (rwRst[i] & ~rwMask[i]);
      rd(rwAddr[i], e);
      if (i > 2) note(raw[i - 3], e);
    end
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(8'h07, d);
      wr(8'h20, d);
      note({1'b0, ctl}, {1'b0, d[4], d[0], d[5], d[1], d[2:0]});
    end
    @(negedge clk) overTemp = 1'b1;
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h02);
    @(negedge clk) overTemp = 1'b0;
    rd(8'h02, 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    host.writeReg({DEV_ADDR ^ 7'h01, 1'b0}, 8'h07, 8'h00, nak);
    note({7'h0, nak}, 8'h01);
    rd(8'h07, (d & 8'h77) | 8'h08);
    wr(8'h11, 8'hFF);
    for (int v = 0; v < 16; v++) begin
      @(negedge clk) outputValid = 4'(v);
      rd(8'h11, {&outputValid[1:0], &outputValid[3:2], outputValid[3:2], 1'b0,
                 outputValid[1], 1'b0, outputValid[0]});
    end
    @(negedge clk) extEnable = 4'hF;
    wr(8'h10, 8'h04);
    note({4'h0, regulatorOn}, 8'h02);
    @(negedge clk) extEnable = 4'h0;
    for (int c = 0; c < 20 && regulatorOn !== 4'h0; c++) @(negedge clk);
    note({4'h0, regulatorOn}, 8'h00);
    wr(8'h10, 8'hFF);
    for (int p = 0; p < 8; p++) begin
      wr(8'h07, 8'(p << 4));
      seqRun(1'b1, p);
      seqRun(1'b0, p);
    end
    wr(8'h07, 8'h70);
    fork
      seqRun(1'b1, 7);
      host.writeReg({DEV_ADDR, 1'b0}, 8'h07, 8'h00, nak);
    join
    seqRun(1'b0, 0);
    wrap_up();
  end
endmodule
